//--- hw/light_adc_pkg.sv
// constants shared by the light converter result readout block
// =============================================================
// register map
// =============================================================
package light_adc_pkg;

    localparam logic [7:0] ADDR_CH0_RESULT_LOW = 8'h14;
    localparam logic [7:0] ADDR_CH0_RESULT_HIGH = 8'h15;
    localparam logic [7:0] ADDR_CH1_RESULT_LOW = 8'h16;
    localparam logic [7:0] ADDR_CH1_RESULT_HIGH = 8'h17;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h18;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h19;
    localparam logic [7:0] ADDR_SECONDARY_ID = 8'h1E;

    // =============================================================
    // field positions and values after reset
    // =============================================================
    localparam int SECONDARY_ID_FLAG_BIT = 7;
    localparam logic [6:0] SECONDARY_ID_RESERVED_RESET = 7'h00;
    localparam logic [7:0] RESULT_BYTE_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // =============================================================
    // timing
    // =============================================================
    localparam int CLK_PERIOD_PS = 10000;
    // one count step of the manual integration timer, 10.9 us
    localparam int COUNT_STEP_PS = 10900000;
    localparam int COUNT_STEP_CYCLES = COUNT_STEP_PS / CLK_PERIOD_PS;
    localparam int STEP_WIDTH = $clog2(COUNT_STEP_CYCLES);

endpackage : light_adc_pkg

//--- hw/result_shadow.sv
// one channel result holder with its upper byte shadow latch
`timescale 1ns/1ps

module result_shadow
    import light_adc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [15:0] i_result,
    input wire logic i_capture,
    output logic [15:0] o_result,
    output logic [7:0] o_shadow
);
    import light_adc_pkg::*;

    logic [15:0] next_result;
    logic [7:0] next_shadow;

    // =============================================================
    // next state
    // =============================================================
    always_comb
    begin
        next_result = o_result;
        next_shadow = o_shadow;
        // R2: only conversions load the result
        if (i_load)
        begin
            next_result = i_result;
        end
        // R5: lower byte read strobes upper bits
        if (i_capture)
        begin
            next_shadow = o_result[15:8];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_result <= RESULT_RESET;
            // R12: shadow zero until first strobe
            o_shadow <= RESULT_BYTE_RESET;
        end
        else
        begin
            o_result <= next_result;
            o_shadow <= next_shadow;
        end
    end

endmodule : result_shadow

//--- hw/integration_timer.sv
// manual integration elapsed time counter in fixed steps
`timescale 1ns/1ps

module integration_timer
    import light_adc_pkg::*;
#(
    parameter int STEP_CYCLES = COUNT_STEP_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_active,
    output logic [15:0] o_count
);
    import light_adc_pkg::*;

    // prescaler sized from the parameter so any step length fits
    localparam int PRESCALE_WIDTH = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
    localparam logic [PRESCALE_WIDTH-1:0] STEP_LAST = PRESCALE_WIDTH'(STEP_CYCLES - 1);

    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [PRESCALE_WIDTH-1:0] next_prescale;
    logic [15:0] next_count;
    logic active_d;

    // =============================================================
    // next state
    // =============================================================
    always_comb
    begin
        next_prescale = prescale;
        next_count = o_count;
        if (i_active && !active_d)
        begin
            // fresh integration starts from zero
            next_prescale = '0;
            next_count = COUNT_RESET;
        end
        // R7: one count every step while integrating
        else if (i_active)
        begin
            if (prescale == STEP_LAST)
            begin
                next_prescale = '0;
                // wraps past 16 bits; the host keeps periods short
                next_count = o_count + 16'h0001;
            end
            else
            begin
                next_prescale = prescale + PRESCALE_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prescale <= '0;
            o_count <= COUNT_RESET;
            active_d <= 1'b0;
        end
        else
        begin
            prescale <= next_prescale;
            o_count <= next_count;
            active_d <= i_active;
        end
    end

    chk_count_step_one: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        $past(active_d && i_active)
        |-> (o_count == $past(o_count) || o_count == $past(o_count) + 16'h0001))
        else $error("integration count moved by other than one step");

    chk_count_restart: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        (i_active && !active_d) |=> (o_count == COUNT_RESET && prescale == '0))
        else $error("a new integration did not restart the count");

    chk_prescale_bound: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        (prescale == STEP_LAST && i_active && active_d) |=> (prescale == '0))
        else $error("step prescaler did not wrap at the step length");

endmodule : integration_timer

//--- hw/light_adc_readout.sv
// result, integration timer and identification register readout
// Operation
// R1: each channel result is two bytes, low at the even address, from 14h and 16h.
// R2: result bytes ignore bus writes and read zero until a conversion loads them.
// R3: a word read at a low result byte returns the low and paired high byte together.
// R4: the host reads a channel's low byte before its high byte.
// R5: reading a low result byte copies that channel's upper bits into its shadow.
// R6: reading a high result byte returns the shadow, coherent with the low byte read.
// R7: a manual integration counts elapsed time in 10.9 us steps into 16 bits.
// R8: the integration count reads low at 18h and high at 19h, zero after reset.
// R9: the host keeps a manual integration within 714.3 ms to avoid overflow.
// R10: register 1Eh carries a fixed identification flag in bit 7, bits 6 to 0 reserved.
// R11: the host should never write register 1Eh even though it accepts writes.
// R12: a high byte read without a prior low byte read returns the last shadow, zero at start.
`timescale 1ns/1ps

module light_adc_readout
    import light_adc_pkg::*;
#(
    // identification flag value, arbitrary
    parameter logic ID_FLAG = 1'b0,
    parameter int STEP_CYCLES = COUNT_STEP_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rd,
    input wire logic i_rd_word,
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_result_load,
    input wire logic [15:0] i_ch0_result,
    input wire logic [15:0] i_ch1_result,
    input wire logic i_manual_active,
    output logic [15:0] o_rdata,
    output logic o_rd_valid
);
    import light_adc_pkg::*;

    logic [15:0] ch_result [2];
    logic [7:0] ch_shadow [2];
    logic [15:0] conv_in [2];
    logic [1:0] capture;
    logic [7:0] eff_shadow [2];
    logic [15:0] manual_count;
    logic [7:0] secondary_id;
    logic [7:0] next_secondary_id;
    logic [15:0] next_rdata;
    logic next_rd_valid;
    logic [7:0] addr_next;

    localparam logic [7:0] SECONDARY_ID_RESET = {ID_FLAG, SECONDARY_ID_RESERVED_RESET};

    assign conv_in[0] = i_ch0_result;
    assign conv_in[1] = i_ch1_result;
    assign addr_next = i_addr + 8'h01;

    // =============================================================
    // channel results and shadows
    // =============================================================
    // R5: a byte or word read at the low address strobes the shadow
    assign capture[0] = i_rd && (i_addr == ADDR_CH0_RESULT_LOW);
    assign capture[1] = i_rd && (i_addr == ADDR_CH1_RESULT_LOW);

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_channel
            result_shadow u_result_shadow (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_load(i_result_load),
                .i_result(conv_in[ch]),
                .i_capture(capture[ch]),
                .o_result(ch_result[ch]),
                .o_shadow(ch_shadow[ch])
            );
            // a word read sees the value being strobed this very cycle
            assign eff_shadow[ch] = capture[ch] ? ch_result[ch][15:8] : ch_shadow[ch];
        end
    endgenerate

    // =============================================================
    // manual integration timer
    // =============================================================
    integration_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_integration_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_active(i_manual_active),
        .o_count(manual_count)
    );

    // =============================================================
    // read decode
    // =============================================================
    function automatic logic [7:0] read_byte(
        input logic [7:0] addr,
        input logic [15:0] res0,
        input logic [15:0] res1,
        input logic [7:0] sh0,
        input logic [7:0] sh1,
        input logic [15:0] cnt,
        input logic [7:0] sid
    );
        logic [7:0] value;
        value = UNMAPPED_READ;
        // R1: low bytes at even addresses
        if (addr == ADDR_CH0_RESULT_LOW)
        begin
            value = res0[7:0];
        end
        // R6: high bytes come from the shadow
        else if (addr == ADDR_CH0_RESULT_HIGH)
        begin
            value = sh0;
        end
        else if (addr == ADDR_CH1_RESULT_LOW)
        begin
            value = res1[7:0];
        end
        else if (addr == ADDR_CH1_RESULT_HIGH)
        begin
            value = sh1;
        end
        // R8: integration count bytes
        else if (addr == ADDR_COUNT_LOW)
        begin
            value = cnt[7:0];
        end
        else if (addr == ADDR_COUNT_HIGH)
        begin
            value = cnt[15:8];
        end
        // R10: identification flag in the top bit
        else if (addr == ADDR_SECONDARY_ID)
        begin
            value = sid;
        end
        return value;
    endfunction : read_byte

    always_comb
    begin
        next_rdata = 16'h0000;
        next_rd_valid = 1'b0;
        if (i_rd)
        begin
            next_rd_valid = 1'b1;
            next_rdata[7:0] = read_byte(i_addr, ch_result[0], ch_result[1],
                eff_shadow[0], eff_shadow[1], manual_count, secondary_id);
            // R3: word read pairs the following byte in the same answer
            if (i_rd_word)
            begin
                next_rdata[15:8] = read_byte(addr_next, ch_result[0], ch_result[1],
                    eff_shadow[0], eff_shadow[1], manual_count, secondary_id);
            end
        end
    end

    // =============================================================
    // write decode
    // =============================================================
    always_comb
    begin
        next_secondary_id = secondary_id;
        // R2: result and count bytes take no writes
        if (i_wr && (i_addr == ADDR_SECONDARY_ID))
        begin
            // stored as written; software is expected to leave it alone
            next_secondary_id = i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= 16'h0000;
            o_rd_valid <= 1'b0;
            secondary_id <= SECONDARY_ID_RESET;
        end
        else
        begin
            o_rdata <= next_rdata;
            o_rd_valid <= next_rd_valid;
            secondary_id <= next_secondary_id;
        end
    end

    // =============================================================
    // checks
    // =============================================================
    chk_low_byte_read: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        (i_rd && !i_rd_word && i_addr == ADDR_CH0_RESULT_LOW)
        |=> (o_rd_valid && o_rdata == {8'h00, $past(ch_result[0][7:0])}))
        else $error("channel zero low byte read returned a wrong value");

    chk_result_read_only: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        (i_wr && !i_result_load)
        |=> ($stable(ch_result[0]) && $stable(ch_result[1])))
        else $error("a bus write altered a channel result");

    chk_word_pair: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        (i_rd && i_rd_word && i_addr == ADDR_CH1_RESULT_LOW)
        |=> (o_rd_valid && o_rdata == $past(ch_result[1])))
        else $error("word read did not return the full channel one value");

    chk_shadow_capture: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        (i_rd && i_addr == ADDR_CH0_RESULT_LOW)
        |=> (ch_shadow[0] == $past(ch_result[0][15:8])))
        else $error("low byte read did not strobe the channel zero shadow");

    chk_high_from_shadow: assert property (@(posedge i_clk) disable iff (i_rst) // R6
        (i_rd && !i_rd_word && i_addr == ADDR_CH1_RESULT_HIGH)
        |=> (o_rdata[7:0] == $past(ch_shadow[1])))
        else $error("high byte read did not return the shadow");

    chk_count_high_read: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        (i_rd && !i_rd_word && i_addr == ADDR_COUNT_HIGH)
        |=> (o_rdata == {8'h00, $past(manual_count[15:8])}))
        else $error("integration count upper byte read wrong");

    chk_id_flag: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        (i_rd && i_addr == ADDR_SECONDARY_ID)
        |=> (o_rdata[SECONDARY_ID_FLAG_BIT] == $past(secondary_id[SECONDARY_ID_FLAG_BIT])))
        else $error("identification flag read mismatch");

    chk_shadow_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        !(i_rd && (i_addr == ADDR_CH0_RESULT_LOW))
        |=> $stable(ch_shadow[0]))
        else $error("channel zero shadow changed without a low byte read");

    // =============================================================
    // read answer, shadow, load and identification write checks
    // =============================================================
    chk_ch0_word_pair: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        (i_rd && i_rd_word && i_addr == ADDR_CH0_RESULT_LOW)
        |=> (o_rd_valid && o_rdata == $past(ch_result[0])))
        else $error("word read did not return the full channel zero value");

    chk_ch1_low_read: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        (i_rd && !i_rd_word && i_addr == ADDR_CH1_RESULT_LOW)
        |=> (o_rdata == {8'h00, $past(ch_result[1][7:0])}))
        else $error("channel one low byte read returned a wrong value");

    chk_ch1_shadow_capture: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        (i_rd && i_addr == ADDR_CH1_RESULT_LOW)
        |=> (ch_shadow[1] == $past(ch_result[1][15:8])))
        else $error("low byte read did not strobe the channel one shadow");

    chk_ch0_high_shadow: assert property (@(posedge i_clk) disable iff (i_rst) // R6
        (i_rd && !i_rd_word && i_addr == ADDR_CH0_RESULT_HIGH)
        |=> (o_rdata == {8'h00, $past(ch_shadow[0])}))
        else $error("channel zero high byte read did not return the shadow");

    chk_ch1_shadow_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        !(i_rd && (i_addr == ADDR_CH1_RESULT_LOW))
        |=> $stable(ch_shadow[1]))
        else $error("channel one shadow changed without a low byte read");

    chk_count_low_read: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        (i_rd && !i_rd_word && i_addr == ADDR_COUNT_LOW)
        |=> (o_rdata == {8'h00, $past(manual_count[7:0])}))
        else $error("integration count lower byte read wrong");

    chk_count_word: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        (i_rd && i_rd_word && i_addr == ADDR_COUNT_LOW)
        |=> (o_rdata == $past(manual_count)))
        else $error("integration count word read wrong");

    chk_read_answer: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        i_rd |=> o_rd_valid)
        else $error("read request got no answer in the next cycle");

    chk_valid_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        !i_rd |=> (!o_rd_valid && o_rdata == 16'h0000))
        else $error("read answer stood without a read request");

    chk_result_load: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        i_result_load
        |=> (ch_result[0] == $past(i_ch0_result) && ch_result[1] == $past(i_ch1_result)))
        else $error("conversion load did not reach the channel results");

    chk_unmapped_read: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        (i_rd && !i_rd_word && i_addr > ADDR_SECONDARY_ID)
        |=> (o_rdata == {8'h00, UNMAPPED_READ}))
        else $error("unmapped address read returned data");

    chk_id_write: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        (i_wr && i_addr == ADDR_SECONDARY_ID)
        |=> (secondary_id == $past(i_wdata)))
        else $error("identification register did not take the written byte");

    chk_byte_upper_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        (i_rd && !i_rd_word)
        |=> (o_rdata[15:8] == 8'h00))
        else $error("byte read left data in the upper half");

    chk_id_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        !(i_wr && i_addr == ADDR_SECONDARY_ID)
        |=> $stable(secondary_id))
        else $error("identification register changed without a write");

endmodule : light_adc_readout

//--- tb/bus_host.sv
// host side register access model for the light converter readout
`timescale 1ns/1ps

module bus_host
(
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_rd_valid,
    output logic o_rd,
    output logic o_rd_word,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        o_rd = 1'b0;
        o_rd_word = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // =============================================================
    // bus cycles
    // =============================================================
    // low byte first: callers order the reads, the model never reorders
    task automatic do_read(input logic [7:0] a, input logic w, output logic [15:0] d,
        output logic v);
        @(posedge i_clk);
        #1;
        o_rd = 1'b1;
        o_rd_word = w;
        o_addr = a;
        @(posedge i_clk);
        #1;
        d = i_rdata;
        v = i_rd_valid;
        o_rd = 1'b0;
        o_rd_word = ~w;
        // released address must not look like the last one
        o_addr = ~a;
    endtask : do_read

    // register writes, result bytes or identification: issued only where a scenario asks for one
    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : do_write
endmodule : bus_host

//--- tb/testbench.sv
// self-checking bench for the light converter result readout
`timescale 1ns/1ps

module testbench;
    import light_adc_pkg::*;
    localparam int STEP = 4;
    // identification flag value, arbitrary
    localparam logic ID = 1'b0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd, rd_word, wr, result_load, manual_active;
    logic [7:0] addr, wdata;
    logic [15:0] ch0, ch1, rdata;
    logic rd_valid;
    int miscompares = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    light_adc_readout #(.ID_FLAG(ID), .STEP_CYCLES(STEP)) uut (.i_clk(clk), .i_rst(rst),
        .i_rd(rd), .i_rd_word(rd_word), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
        .i_result_load(result_load), .i_ch0_result(ch0), .i_ch1_result(ch1),
        .i_manual_active(manual_active), .o_rdata(rdata), .o_rd_valid(rd_valid));

    bus_host host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_rd(rd),
        .o_rd_word(rd_word), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

    // =============================================================
    // helpers
    // =============================================================
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic w, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host.do_read(a, w, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask : rd_chk

    task automatic load(input logic [15:0] r0, input logic [15:0] r1);
        @(posedge clk);
        #1;
        result_load = 1'b1;
        ch0 = r0;
        ch1 = r1;
        @(posedge clk);
        #1;
        result_load = 1'b0;
        ch0 = ~r0;
        ch1 = ~r1;
    endtask : load

    task automatic run_timer(input int edges);
        @(posedge clk);
        #1;
        manual_active = 1'b1;
        repeat (edges) @(posedge clk);
        #1;
        manual_active = 1'b0;
    endtask : run_timer

    // =============================================================
    // scenarios
    // =============================================================
    task automatic t_reset();
        rd_chk(ADDR_CH0_RESULT_HIGH, 1'b0, 16'h0000);
        for (int i = 0; i < 6; i++)
            rd_chk(8'(8'h14 + i), 1'b0, 16'h0000);
        rd_chk(ADDR_SECONDARY_ID, 1'b0, {8'h00, ID, 7'h00});
        rd_chk(8'h1F, 1'b0, 16'h0000);
    endtask : t_reset

    task automatic t_word();
        load(16'hA1B2, 16'hC3D4);
        rd_chk(ADDR_CH1_RESULT_HIGH, 1'b0, 16'h0000);
        rd_chk(ADDR_CH0_RESULT_LOW, 1'b1, 16'hA1B2);
        rd_chk(ADDR_CH1_RESULT_LOW, 1'b1, 16'hC3D4);
        rd_chk(ADDR_CH0_RESULT_LOW, 1'b0, 16'h00B2);
        rd_chk(ADDR_CH0_RESULT_HIGH, 1'b0, 16'h00A1);
        @(posedge clk);
        #1;
        check(rdata, 16'h0000);
        check({15'h0000, rd_valid}, 16'h0000);
    endtask : t_word

    task automatic t_shadow();
        rd_chk(ADDR_CH1_RESULT_LOW, 1'b0, 16'h00D4);
        rd_chk(ADDR_CH0_RESULT_LOW, 1'b0, 16'h00B2);
        load(16'h5566, 16'h7788);
        rd_chk(ADDR_CH0_RESULT_HIGH, 1'b0, 16'h00A1);
        rd_chk(ADDR_CH1_RESULT_HIGH, 1'b0, 16'h00C3);
        rd_chk(ADDR_CH1_RESULT_LOW, 1'b1, 16'h7788);
        rd_chk(ADDR_CH1_RESULT_HIGH, 1'b0, 16'h0077);
    endtask : t_shadow

    task automatic t_write();
        logic [15:0] exp_tab [6] = '{16'h0066, 16'h0055, 16'h0088, 16'h0077, 16'h0000,
            16'h0000};
        for (int i = 0; i < 6; i++)
            host.do_write(8'(8'h14 + i), 8'hFF);
        for (int i = 0; i < 6; i++)
            rd_chk(8'(8'h14 + i), 1'b0, exp_tab[i]);
        host.do_write(ADDR_SECONDARY_ID, 8'h5A);
        rd_chk(ADDR_SECONDARY_ID, 1'b0, 16'h005A);
        host.do_write(ADDR_SECONDARY_ID, {ID, 7'h00});
        rd_chk(ADDR_SECONDARY_ID, 1'b0, {8'h00, ID, 7'h00});
    endtask : t_write

    // runs end mid-step so an edge either way gives the same count
    task automatic t_timer();
        run_timer(43);
        rd_chk(ADDR_COUNT_LOW, 1'b1, 16'h000A);
        rd_chk(ADDR_COUNT_HIGH, 1'b0, 16'h0000);
        repeat (10) @(posedge clk);
        rd_chk(ADDR_COUNT_LOW, 1'b0, 16'h000A);
        run_timer(11);
        rd_chk(ADDR_COUNT_LOW, 1'b1, 16'h0002);
    endtask : t_timer

    // second reset in mid-run must clear results, the channel one shadow, count and id
    task automatic t_rereset();
        host.do_write(ADDR_SECONDARY_ID, 8'h5A);
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_chk(ADDR_CH1_RESULT_HIGH, 1'b0, 16'h0000);
        for (int i = 0; i < 6; i++)
            rd_chk(8'(8'h14 + i), 1'b0, 16'h0000);
        rd_chk(ADDR_SECONDARY_ID, 1'b0, {8'h00, ID, 7'h00});
    endtask : t_rereset

    // =============================================================
    // run control
    // =============================================================
    task automatic results();
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    initial
    begin
        #200000;
        miscompares++;
        results();
    end

    initial
    begin
        result_load = 1'b0;
        manual_active = 1'b0;
        ch0 = 16'h0000;
        ch1 = 16'h0000;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_word();
        t_shadow();
        t_write();
        t_timer();
        t_rereset();
        results();
    end
endmodule : testbench
